// file: core/paged_i2c_regs.svh
/*
 * constants of the paged i2c register slave: address prefix, page pointer
 * offset, reset values and timing counts.
 * assumes it is included by bare name from the design files.
 */
`ifndef PAGED_I2C_REGS_SVH
`define PAGED_I2C_REGS_SVH

`define I2C_ADDR_PREFIX  4'hA
`define PAGE_PTR_OFS     7'h7F
`define PAGE_PTR_RST     8'h00
`define BYTE_BITS        4'h8
`define CLK_PERIOD_NS    50
`define SPIKE_NS         50
`define SPIKE_CYC        ((`SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCL_STD_KHZ      100
`define SCL_FAST_KHZ     400

`endif

// file: core/paged_i2c_pkg.sv
/*
 * types of the paged i2c register slave.
 * assumes nothing beyond a systemverilog compiler.
 */
package paged_i2c_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_OFFS, ST_OFFS_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
    } slave_state_t;

    typedef struct packed {
        logic [9:0] base;
        logic [7:0] len;
    } commit_t;

endpackage

// file: core/reg_mem.sv
/*
 * byte register memory: one write port, two registered read ports.
 * assumes a single clock; contents are undefined until written.
 */
`timescale 1ns/1ns
`default_nettype none

module reg_mem #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    output var  logic [DW-1:0] rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output var  logic [DW-1:0] rdata_b
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata_a <= mem[raddr_a];
        rdata_b <= mem[raddr_b];
    end
endmodule

`default_nettype wire

// file: core/paged_i2c_register_slave.sv
/*
 * paged i2c register slave: filters and decodes the serial pins, answers
 * its strapped address and reads or writes a paged byte register space.
 * assumes scl/sda/straps arrive asynchronously and that the bus wire is
 * resolved outside from sda_oe (open drain, low when enabled).
 */
`timescale 1ns/1ns
`default_nettype none

`include "paged_i2c_regs.svh"

module paged_i2c_register_slave #(
    parameter int PAGE_BITS = 3
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output var  logic                   sda_out,
    output var  logic                   sda_oe,
    input  wire logic                   addr_strap_high,
    input  wire logic                   addr_strap_mid,
    input  wire logic                   addr_strap_space_select,
    output var  logic                   space_sel,
    output var  logic                   cfg_commit,
    output var  paged_i2c_pkg::commit_t cfg_update,
    input  wire logic [PAGE_BITS+6:0]   cfg_raddr,
    output var  logic [7:0]             cfg_rdata
);
    localparam int FW = `SPIKE_CYC + 1;
    localparam int AW = PAGE_BITS + 7;

    paged_i2c_pkg::slave_state_t state;
    logic [1:0]    scl_s, sda_s;
    logic [2:0]    strap_s0, strap_s1;
    logic [FW-1:0] scl_h, sda_h;
    logic          scl_f, sda_f, scl_d, sda_d;
    logic          scl_rise, scl_fall, start_cond, stop_cond;
    logic [3:0]    bit_cnt;
    logic [7:0]    shreg, tx;
    logic          rw, master_nack;
    logic [6:0]    ptr;
    logic [7:0]    page;
    logic [7:0]    wcount;
    logic [9:0]    wbase;
    logic [7:0]    mem_rdata, rd_byte;
    logic          mem_we;
    logic [6:0]    my_addr;
    logic          byte_done;

    function automatic logic all_same(input logic [FW-1:0] h);
        return (h == {FW{1'b0}}) || (h == {FW{1'b1}});
    endfunction

    // pins pass two flops before anything reads them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_s    <= 2'h3;
            sda_s    <= 2'h3;
            strap_s0 <= 3'h0;
            strap_s1 <= 3'h0;
        end else begin
            scl_s    <= {scl_s[0], scl_in};
            sda_s    <= {sda_s[0], sda_in};
            strap_s0 <= {addr_strap_high, addr_strap_mid, addr_strap_space_select};
            strap_s1 <= strap_s0;
        end
    end

    // level only follows once it has held for longer than a spike
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_h <= {FW{1'b1}};
            sda_h <= {FW{1'b1}};
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_h <= {scl_h[FW-2:0], scl_s[1]};
            sda_h <= {sda_h[FW-2:0], sda_s[1]};
            if (all_same(scl_h)) scl_f <= scl_h[0];
            if (all_same(sda_h)) sda_f <= sda_h[0];
            scl_d <= scl_f;
            sda_d <= sda_f;
        end
    end

    // edges found by sampling; 20 MHz covers a 400 kHz scl
    assign scl_rise   = scl_f && !scl_d;
    assign scl_fall   = !scl_f && scl_d;
    assign start_cond = scl_f && scl_d && sda_d && !sda_f;
    assign stop_cond  = scl_f && scl_d && !sda_d && sda_f;

    assign my_addr   = {`I2C_ADDR_PREFIX, strap_s1};
    assign byte_done = scl_fall && (bit_cnt == `BYTE_BITS);
    assign rd_byte   = (ptr == `PAGE_PTR_OFS) ? page : mem_rdata;
    assign mem_we    = byte_done && (state == paged_i2c_pkg::ST_WDATA)
                       && (ptr != `PAGE_PTR_OFS);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) space_sel <= 1'b0;
        else     space_sel <= strap_s1[0];
    end

    // serial state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state       <= paged_i2c_pkg::ST_IDLE;
            bit_cnt     <= 4'h0;
            shreg       <= 8'h00;
            tx          <= 8'h00;
            rw          <= 1'b0;
            master_nack <= 1'b0;
            sda_oe      <= 1'b0;
        end else if (start_cond) begin
            state   <= paged_i2c_pkg::ST_ADDR;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
        end else if (stop_cond) begin
            state  <= paged_i2c_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            if (scl_rise) begin
                if (bit_cnt != `BYTE_BITS) bit_cnt <= bit_cnt + 4'h1;
                shreg   <= {shreg[6:0], sda_f};
                if (state == paged_i2c_pkg::ST_RACK) master_nack <= sda_f;
            end
            if (scl_fall) begin
                unique case (state)
                    paged_i2c_pkg::ST_IDLE: sda_oe <= 1'b0;
                    paged_i2c_pkg::ST_ADDR: begin
                        if (byte_done) begin
                            if (shreg[7:1] == my_addr) begin
                                state  <= paged_i2c_pkg::ST_ADDR_ACK;
                                rw     <= shreg[0];
                                sda_oe <= 1'b1;
                            end else begin
                                state <= paged_i2c_pkg::ST_IDLE;
                            end
                        end
                    end
                    paged_i2c_pkg::ST_ADDR_ACK,
                    paged_i2c_pkg::ST_RACK: begin
                        bit_cnt <= 4'h0;
                        if (state == paged_i2c_pkg::ST_RACK && master_nack) begin
                            state  <= paged_i2c_pkg::ST_IDLE;
                            sda_oe <= 1'b0;
                        end else if (state == paged_i2c_pkg::ST_RACK || rw) begin
                            state  <= paged_i2c_pkg::ST_RDATA;
                            sda_oe <= !rd_byte[7];
                            tx     <= {rd_byte[6:0], 1'b0};
                        end else begin
                            state  <= paged_i2c_pkg::ST_OFFS;
                            sda_oe <= 1'b0;
                        end
                    end
                    paged_i2c_pkg::ST_OFFS,
                    paged_i2c_pkg::ST_WDATA: begin
                        if (byte_done) begin
                            state  <= (state == paged_i2c_pkg::ST_OFFS) ?
                                      paged_i2c_pkg::ST_OFFS_ACK :
                                      paged_i2c_pkg::ST_WDATA_ACK;
                            sda_oe <= 1'b1;
                        end
                    end
                    paged_i2c_pkg::ST_OFFS_ACK,
                    paged_i2c_pkg::ST_WDATA_ACK: begin
                        state   <= paged_i2c_pkg::ST_WDATA;
                        bit_cnt <= 4'h0;
                        sda_oe  <= 1'b0;
                    end
                    paged_i2c_pkg::ST_RDATA: begin
                        if (byte_done) begin
                            state  <= paged_i2c_pkg::ST_RACK;
                            sda_oe <= 1'b0;
                        end else begin
                            sda_oe <= !tx[7];
                            tx     <= {tx[6:0], 1'b0};
                        end
                    end
                endcase
            end
        end
    end

    // address pointer, page pointer and burst bookkeeping
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr    <= 7'h00;
            page   <= `PAGE_PTR_RST;
            wcount <= 8'h00;
            wbase  <= 10'h000;
        end else if (start_cond || stop_cond) begin
            wcount <= 8'h00;
        end else if (byte_done) begin
            unique case (state)
                paged_i2c_pkg::ST_OFFS: begin
                    ptr <= shreg[6:0];
                end
                paged_i2c_pkg::ST_WDATA: begin
                    ptr <= ptr + 7'h01;
                    if (ptr == `PAGE_PTR_OFS) page <= shreg;
                    if (wcount == 8'h00) wbase <= {page[2:0], ptr};
                    if (wcount != 8'hFF) wcount <= wcount + 8'h01;
                end
                paged_i2c_pkg::ST_RDATA: begin
                    ptr <= ptr + 7'h01;
                end
                default: begin
                    ptr <= ptr;
                end
            endcase
        end
    end

    // a write burst is handed on whole once the master ends it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_commit <= 1'b0;
            cfg_update <= '0;
        end else begin
            cfg_commit <= (start_cond || stop_cond) && (wcount != 8'h00);
            if ((start_cond || stop_cond) && (wcount != 8'h00)) begin
                cfg_update.base <= wbase;
                cfg_update.len  <= wcount;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) sda_out <= 1'b0;
        else     sda_out <= 1'b0;
    end

    reg_mem #(.AW(AW), .DW(8)) u_mem (
        .clk     (clk),
        .we      (mem_we),
        .waddr   ({page[PAGE_BITS-1:0], ptr}),
        .wdata   (shreg),
        .raddr_a ({page[PAGE_BITS-1:0], ptr}),
        .rdata_a (mem_rdata),
        .raddr_b (cfg_raddr),
        .rdata_b (cfg_rdata)
    );

    sequence seq_addr_done;
        state == paged_i2c_pkg::ST_ADDR && byte_done;
    endsequence
    sequence seq_wbyte_done;
        state == paged_i2c_pkg::ST_WDATA && byte_done;
    endsequence

    chk_addr_ack: assert property (@(posedge clk) disable iff (rst)
        seq_addr_done ##0 (shreg[7:1] == my_addr) && !start_cond && !stop_cond
        |=> sda_oe && state == paged_i2c_pkg::ST_ADDR_ACK)
        else $error("own address not acknowledged");
    chk_addr_nack: assert property (@(posedge clk) disable iff (rst)
        seq_addr_done ##0 (shreg[7:1] != my_addr) |=> !sda_oe [*2])
        else $error("foreign address acknowledged");
    chk_page_write: assert property (@(posedge clk) disable iff (rst)
        seq_wbyte_done ##0 (ptr == `PAGE_PTR_OFS) && !start_cond && !stop_cond
        |=> page == $past(shreg))
        else $error("page pointer not updated");
    chk_ptr_incr: assert property (@(posedge clk) disable iff (rst)
        seq_wbyte_done ##0 !start_cond && !stop_cond
        |=> ptr == $past(ptr) + 7'h01)
        else $error("write pointer not incremented");
    chk_commit_end: assert property (@(posedge clk) disable iff (rst)
        cfg_commit |-> ($past(start_cond) || $past(stop_cond)) && $past(wcount) != 8'h00)
        else $error("commit outside burst end");
    chk_no_commit_mid: assert property (@(posedge clk) disable iff (rst)
        state == paged_i2c_pkg::ST_WDATA_ACK |-> !cfg_commit)
        else $error("commit during burst");
    chk_spike_filter: assert property (@(posedge clk) disable iff (rst)
        scl_f != scl_d |-> $past(scl_s[1], 2) == $past(scl_s[1], 3))
        else $error("scl spike passed filter");
    chk_bit_count: assert property (@(posedge clk) disable iff (rst)
        scl_rise && bit_cnt == `BYTE_BITS |-> state != paged_i2c_pkg::ST_WDATA
        && state != paged_i2c_pkg::ST_RDATA)
        else $error("byte longer than eight bits");
    chk_page_mem: assert property (@(posedge clk) disable iff (rst)
        mem_we |-> ptr != `PAGE_PTR_OFS)
        else $error("pointer offset written to memory");
endmodule

`default_nettype wire

// file: test/i2c_host_model.sv
/*
 * i2c host model: bit-banged bus master with tasks for start, stop,
 * byte write and byte read.
 * assumes sda is resolved open drain with a pull-up by the bench.
 */
`timescale 1ns/1ns
`default_nettype none

module i2c_host_model (
    output var  logic scl,
    output var  logic sda_low,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // waits out the device's late ack release before raising scl
    task automatic start();
        #300 sda_low = 1'b0;
        #200 scl = 1'b1;
        #300 sda_low = 1'b1;
        #300 scl = 1'b0;
    endtask

    task automatic stop();
        #100 sda_low = 1'b1;
        #400 scl = 1'b1;
        #300 sda_low = 1'b0;
        #500;
    endtask

    // 400 ns bit: long low phase covers the device's answer delay, sampled while high
    task automatic put_bit(input logic b, output logic s);
        #50 sda_low = ~b;
        #250 scl = 1'b1;
        #50 s = sda;
        #50 scl = 1'b0;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    // the host acks every byte but the last of a burst
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, d[i]);
        end
        put_bit(last, s);
    endtask
endmodule

`default_nettype wire

// file: test/paged_i2c_register_slave_tb_top.sv
/*
 * bench of the paged i2c register slave: reset checks, a row loop of page
 * and offset writes, then burst, wrap, foreign address and strap cases.
 * assumes the host model drives scl and pulls sda; sda has a pull-up.
 */
`timescale 1ns/1ns
`default_nettype none

module paged_i2c_register_slave_tb_top;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic [2:0]             strap = 3'h5;
    logic [9:0]             cfg_raddr = 10'h000;
    logic                   scl;
    logic                   host_low;
    logic                   sda_oe;
    logic                   sda_out;
    logic                   space_sel;
    logic                   cfg_commit;
    paged_i2c_pkg::commit_t cfg_update;
    paged_i2c_pkg::commit_t last_upd;
    logic [7:0]             cfg_rdata;
    wire                    sda = ~(sda_oe | host_low);
    int                     fails = 0;
    int                     checked = 0;
    int                     cycles = 0;
    // rows: page, offset, data
    logic [17:0]            rows [4] = '{18'h003C, 18'h110A5, 18'h3FE01, 18'h2C0FF};

    always #25 clk = ~clk;

    i2c_host_model u_host (.scl(scl), .sda_low(host_low), .sda(sda));

    paged_i2c_register_slave u_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_high(strap[2]), .addr_strap_mid(strap[1]),
        .addr_strap_space_select(strap[0]), .space_sel(space_sel), .cfg_commit(cfg_commit),
        .cfg_update(cfg_update), .cfg_raddr(cfg_raddr), .cfg_rdata(cfg_rdata));

    task automatic complete_run();
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic ack;
        u_host.wr_byte(d, ack);
        check(ack, exp_ack);
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d[$]);
        u_host.start();
        send({4'hA, strap, 1'b0}, 1'b1);
        send(ofs, 1'b1);
        foreach (d[i]) send(d[i], 1'b1);
        u_host.stop();
    endtask

    task automatic rd(input logic cur, input logic [7:0] ofs, input logic [7:0] exp[$]);
        logic [7:0] b;
        u_host.start();
        if (!cur) begin
            send({4'hA, strap, 1'b0}, 1'b1);
            send(ofs, 1'b1);
            u_host.start();
        end
        send({4'hA, strap, 1'b1}, 1'b1);
        foreach (exp[i]) begin
            u_host.rd_byte(i == exp.size() - 1, b);
            check(b, exp[i]);
        end
        u_host.stop();
    endtask

    task automatic mem(input logic [9:0] a, input logic [7:0] exp);
        @(negedge clk) cfg_raddr = a;
        @(negedge clk);
        @(negedge clk) check(cfg_rdata, exp);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cfg_commit === 1'b1) last_upd <= cfg_update;
        if (cycles == 60000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        repeat (12) @(negedge clk);
        check(sda_oe, 1'b0);
        rst = 1'b0;
        repeat (12) @(negedge clk);
        check({sda_oe, cfg_commit, cfg_update}, 20'h0);
        check(sda_out, 1'b0);
        check(space_sel, strap[0]);
        foreach (rows[i]) begin
            wr(8'h7F, '{{5'h0, rows[i][17:15]}});
            wr({1'b0, rows[i][14:8]}, '{rows[i][7:0]});
            mem(rows[i][17:8], rows[i][7:0]);
            rd(1'b0, {1'b0, rows[i][14:8]}, '{rows[i][7:0]});
            rd(1'b0, 8'h7F, '{{5'h0, rows[i][17:15]}});
        end
        wr(8'h7F, '{8'h02});
        wr(8'h00, '{8'h11, 8'h22});
        check(last_upd, {10'h100, 8'h02});
        mem(10'h101, 8'h22);
        rd(1'b0, 8'h00, '{8'h11, 8'h22});
        wr(8'h20, '{8'hAA, 8'hBB, 8'hCC});
        rd(1'b0, 8'h20, '{8'hAA});
        rd(1'b1, 8'h00, '{8'hBB, 8'hCC});
        wr(8'h7E, '{8'h77});
        wr(8'h00, '{8'h5A});
        rd(1'b0, 8'h7E, '{8'h77, 8'h02, 8'h5A});
        u_host.start();
        send({4'hA, strap[2:1], ~strap[0], 1'b0}, 1'b0);
        u_host.stop();
        u_host.start();
        send({4'h2, strap, 1'b0}, 1'b0);
        u_host.stop();
        // second reset with other straps: new address, page pointer back to zero
        @(negedge clk) strap = 3'h2;
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (12) @(negedge clk);
        check(space_sel, 1'b0);
        rd(1'b0, 8'h7F, '{8'h00});
        complete_run();
    end
endmodule

`default_nettype wire
